// file: ihct_hcount.sv
// Horizontal raster counter in eight-pixel units
`default_nettype none
module ihct_hcount
    import ihct_pkg::*;
(
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    input  wire logic          enable,
    input  wire ihct_htiming_t timing,
    output logic [7:0]         unit_pos,
    output logic               line_start,
    output logic               h_active,
    output logic               h_blank
);
    logic [7:0] pos_reg;
    logic [7:0] pos_next;
    logic       act_reg;
    logic       blk_reg;
    logic       sol_reg;
    wire        at_end   = (pos_reg == timing.total);

    // Unit n spans pixels n*8 .. n*8+7, so a limit n covers (n+1)*8 pixels
    assign pos_next = (!enable || at_end) ? 8'h00 : pos_reg + 8'h01;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !enable) begin
            pos_reg <= 8'h00;
            act_reg <= 1'b0;
            blk_reg <= 1'b1;
            sol_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            act_reg <= (pos_next <= timing.disp_end);
            blk_reg <= (pos_next > timing.blank_start);
            sol_reg <= at_end;
        end
    end

    assign unit_pos   = pos_reg;
    assign line_start = sol_reg;
    assign h_active   = act_reg;
    assign h_blank    = blk_reg;
endmodule
`default_nettype wire

// file: ihct_host.sv
// Host processor model driving the indexed I/O port
`default_nettype none
module ihct_host
    import ihct_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        io_rvalid,
    input  wire logic [31:0] io_rdata,
    output var ihct_io_req_t io_req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial io_req = '0;
    // Callers select only mapped indices
    task automatic io_write(input logic [3:0] a, input ihct_size_t s,
                            input logic [31:0] d);
        @(posedge ref_clk);
        #1;
        io_req = '{wr: 1'b1, rd: 1'b0, addr: a, size: s, wdata: d};
        @(posedge ref_clk);
        #1;
        io_req.wr = 1'b0;
        // A released bus must not keep showing the last value
        io_req.wdata = ~d;
    endtask
    task automatic io_read(input logic [3:0] a, input ihct_size_t s,
                           output logic [31:0] d, output logic ok);
        ok = 1'b0;
        d = '0;
        @(posedge ref_clk);
        #1;
        io_req = '{wr: 1'b0, rd: 1'b1, addr: a, size: s, wdata: 32'h0};
        @(posedge ref_clk);
        #1;
        io_req.rd = 1'b0;
        // The answer stands for the one cycle after the taking edge
        for (int i = 0; i < 4 && !ok; i++) begin
            ok = (io_rvalid === 1'b1);
            d = io_rdata;
            if (!ok) begin
                @(posedge ref_clk);
                #1;
            end
        end
    endtask
endmodule
`default_nettype wire

// file: ihct_pkg.sv
// Shared constants and types for the indexed horizontal timing block
`default_nettype none
package ihct_pkg;
    // Port offsets within the I/O block (low nibble of address)
    localparam logic [3:0] IHCT_PORT_MODE  = 4'h0;
    localparam logic [3:0] IHCT_PORT_INDEX = 4'hA;
    localparam logic [3:0] IHCT_PORT_DATA0 = 4'hB;
    localparam logic [3:0] IHCT_PORT_DATA1 = 4'hC;
    localparam logic [3:0] IHCT_PORT_DATAL = 4'hF;
    // Indexed register map
    localparam logic [7:0] IHCT_IDX_AUTOCFG  = 8'h04;
    localparam logic [7:0] IHCT_IDX_SRA      = 8'h0C;
    localparam logic [7:0] IHCT_IDX_SRB      = 8'h0D;
    localparam logic [7:0] IHCT_IDX_HTOT_LO  = 8'h10;
    localparam logic [7:0] IHCT_IDX_HTOT_HI  = 8'h11;
    localparam logic [7:0] IHCT_IDX_HDE_LO   = 8'h12;
    localparam logic [7:0] IHCT_IDX_HDE_HI   = 8'h13;
    localparam logic [7:0] IHCT_IDX_HBS_LO   = 8'h14;
    localparam logic [7:0] IHCT_IDX_HBS_HI   = 8'h15;
    localparam logic [7:0] IHCT_IDX_HBE_LO   = 8'h16;
    localparam logic [7:0] IHCT_IDX_HSE_HI   = 8'h1B;
    localparam logic [7:0] IHCT_IDX_HSP_A    = 8'h1C;
    localparam logic [7:0] IHCT_IDX_HSP_B    = 8'h1E;
    localparam logic [7:0] IHCT_IDX_SPR_LO   = 8'h30;
    localparam logic [7:0] IHCT_IDX_SPR_HI   = 8'h36;
    localparam logic [7:0] IHCT_IDX_PAL_LO   = 8'h50;
    localparam logic [7:0] IHCT_IDX_PAL_HI   = 8'h60;
    // Field positions and values
    localparam int         IHCT_BUS_WIDTH_BIT = 0;
    localparam logic [2:0] IHCT_MODE_EXT      = 3'b100;
    localparam int         IHCT_MODE_LSB      = 0;
    localparam logic [7:0] IHCT_RESET_BYTE    = 8'h00;
    localparam logic [7:0] IHCT_RESERVED_READ = 8'h00;
    localparam int         IHCT_PIX_PER_UNIT  = 8;
    localparam int         IHCT_CNT_W         = 11;

    // Access size on the host I/O bus
    typedef enum logic [1:0] {
        IHCT_SZ_BYTE,
        IHCT_SZ_WORD,
        IHCT_SZ_DWORD
    } ihct_size_t;

    // One host I/O cycle
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        ihct_size_t  size;
        logic [31:0] wdata;
    } ihct_io_req_t;

    // Horizontal timing set handed to the raster counter
    typedef struct packed {
        logic [7:0] total;
        logic [7:0] disp_end;
        logic [7:0] blank_start;
    } ihct_htiming_t;
endpackage
`default_nettype wire

// file: ihct_regs.sv
// Indexed register access port with horizontal timing registers
`default_nettype none
import ihct_pkg::*;
module ihct_regs
    import ihct_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire ihct_io_req_t      io_req,
    output logic [DATA_W-1:0]      io_rdata,
    output logic                   io_rvalid,
    input  wire logic              bus_width_flag,
    input  wire logic [7:0]        cop_sr_a_in,
    input  wire logic [7:0]        cop_sr_b_in,
    output logic [7:0]             cop_sr_data,
    output logic                   cop_sr_a_wr,
    output logic                   cop_sr_b_wr,
    output logic                   cop_sr_a_rd,
    output logic                   cop_sr_b_rd,
    output logic [7:0]             ext_index,
    output logic [7:0]             ext_wdata,
    output logic                   ext_wr,
    output logic                   ext_rd,
    input  wire logic [7:0]        ext_rdata,
    output logic                   ext_sprite_sel,
    output logic                   ext_palette_sel,
    output logic [7:0]             h_unit_pos,
    output logic                   h_line_start,
    output logic                   h_active,
    output logic                   h_blank,
    output logic                   ext_mode
);
    // Returns how many byte accesses an I/O cycle of a given size makes
    function automatic logic [2:0] byte_count(input ihct_size_t sz);
        case (sz)
            IHCT_SZ_WORD:  byte_count = 3'd2;
            IHCT_SZ_DWORD: byte_count = 3'd4;
            default:       byte_count = 3'd1;
        endcase
    endfunction

    // Picks byte lane n out of a 32-bit data word
    function automatic logic [7:0] lane(input logic [31:0] w,
                                        input logic [1:0]  n);
        lane = w[8*n +: 8];
    endfunction

    logic [7:0]  index_reg;
    logic [7:0]  index_next;
    logic [2:0]  mode_reg;
    logic        bw_meta_reg;
    logic        bw_sync_reg;
    logic [7:0]  htot_lo_reg;
    logic [7:0]  htot_hi_reg;
    logic [7:0]  hde_lo_reg;
    logic [7:0]  hde_hi_reg;
    logic [7:0]  hbs_lo_reg;
    logic [7:0]  hbs_hi_reg;
    logic [31:0] rdata_reg;
    logic        rvalid_reg;
    logic [7:0]  cop_data_reg;
    logic        cop_a_wr_reg;
    logic        cop_b_wr_reg;
    logic        cop_a_rd_reg;
    logic        cop_b_rd_reg;
    logic [7:0]  ext_wdata_reg;
    logic        ext_wr_reg;
    logic        ext_rd_reg;

    // Port decode
    wire is_index = (io_req.addr == IHCT_PORT_INDEX);
    wire is_data  = (io_req.addr >= IHCT_PORT_DATA0) &&
                    (io_req.addr <= IHCT_PORT_DATAL);
    wire is_mode  = (io_req.addr == IHCT_PORT_MODE);
    wire idx_wr   = io_req.wr && is_index;
    // Word write at the index port carries data in its high byte
    wire idx_data = idx_wr && (io_req.size != IHCT_SZ_BYTE);
    wire data_wr  = io_req.wr && is_data;
    wire data_rd  = io_req.rd && is_data;
    wire [2:0] n_bytes = byte_count(io_req.size);

    // Index for this cycle: a word write at the index port takes effect
    // for its own data byte, so the new index is used at once
    assign index_next = idx_wr ? io_req.wdata[7:0] : index_reg;

    // Every byte of a wide data write lands on the same indexed register;
    // the last byte written is the one that stays, as with n byte writes
    wire [1:0] last_lane = 2'(n_bytes - 3'd1);
    wire [7:0] wr_byte   = idx_data ? io_req.wdata[15:8]
                                    : lane(io_req.wdata, last_lane);
    wire       byte_wr   = data_wr || idx_data;

    // Indexed register selects
    wire sel_autocfg = (index_next == IHCT_IDX_AUTOCFG);
    wire sel_sra     = (index_next == IHCT_IDX_SRA);
    wire sel_srb     = (index_next == IHCT_IDX_SRB);
    wire sel_htot_lo = (index_next == IHCT_IDX_HTOT_LO);
    wire sel_htot_hi = (index_next == IHCT_IDX_HTOT_HI);
    wire sel_hde_lo  = (index_next == IHCT_IDX_HDE_LO);
    wire sel_hde_hi  = (index_next == IHCT_IDX_HDE_HI);
    wire sel_hbs_lo  = (index_next == IHCT_IDX_HBS_LO);
    wire sel_hbs_hi  = (index_next == IHCT_IDX_HBS_HI);
    // Blanking end through sync position live in the outer timing logic
    wire sel_hext    = ((index_next >= IHCT_IDX_HBE_LO) &&
                        (index_next <= IHCT_IDX_HSE_HI)) ||
                       (index_next == IHCT_IDX_HSP_A) ||
                       (index_next == IHCT_IDX_HSP_B);
    wire sel_spr     = (index_next >= IHCT_IDX_SPR_LO) &&
                       (index_next <= IHCT_IDX_SPR_HI);
    wire sel_pal     = (index_next >= IHCT_IDX_PAL_LO) &&
                       (index_next <= IHCT_IDX_PAL_HI);
    wire sel_ext     = sel_hext || sel_spr || sel_pal;

    // Read byte for the selected index; reserved indices read as zero
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = IHCT_RESERVED_READ;
        if (sel_autocfg) begin
            rd_byte = IHCT_RESERVED_READ;
            rd_byte[IHCT_BUS_WIDTH_BIT] = bw_sync_reg;
        end else if (sel_sra) begin
            rd_byte = cop_sr_a_in;
        end else if (sel_srb) begin
            rd_byte = cop_sr_b_in;
        end else if (sel_htot_lo) begin
            rd_byte = htot_lo_reg;
        end else if (sel_htot_hi) begin
            rd_byte = htot_hi_reg;
        end else if (sel_hde_lo) begin
            rd_byte = hde_lo_reg;
        end else if (sel_hde_hi) begin
            rd_byte = hde_hi_reg;
        end else if (sel_hbs_lo) begin
            rd_byte = hbs_lo_reg;
        end else if (sel_hbs_hi) begin
            rd_byte = hbs_hi_reg;
        end else if (sel_ext) begin
            rd_byte = ext_rdata;
        end
    end

    // A wide read returns the same register in each active lane
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            if (3'(i) < n_bytes) begin
                rd_word[8*i +: 8] = rd_byte;
            end
        end
    end

    // Index and mode registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            index_reg <= IHCT_RESET_BYTE;
            mode_reg  <= 3'b000;
        end else begin
            index_reg <= index_next;
            if (io_req.wr && is_mode) begin
                mode_reg <= io_req.wdata[IHCT_MODE_LSB +: 3];
            end
        end
    end

    // Strap level from the board, brought in through two flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bw_meta_reg <= 1'b0;
            bw_sync_reg <= 1'b0;
        end else begin
            bw_meta_reg <= bus_width_flag;
            bw_sync_reg <= bw_meta_reg;
        end
    end

    // Horizontal timing registers; index 04 has no write path
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            htot_lo_reg <= IHCT_RESET_BYTE;
            htot_hi_reg <= IHCT_RESET_BYTE;
            hde_lo_reg  <= IHCT_RESET_BYTE;
            hde_hi_reg  <= IHCT_RESET_BYTE;
            hbs_lo_reg  <= IHCT_RESET_BYTE;
            hbs_hi_reg  <= IHCT_RESET_BYTE;
        end else if (byte_wr) begin
            if (sel_htot_lo) htot_lo_reg <= wr_byte;
            if (sel_htot_hi) htot_hi_reg <= wr_byte;
            if (sel_hde_lo)  hde_lo_reg  <= wr_byte;
            if (sel_hde_hi)  hde_hi_reg  <= wr_byte;
            if (sel_hbs_lo)  hbs_lo_reg  <= wr_byte;
            if (sel_hbs_hi)  hbs_hi_reg  <= wr_byte;
        end
    end

    // Read data, coprocessor image strobes and outer register strobes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_reg     <= 32'h0000_0000;
            rvalid_reg    <= 1'b0;
            cop_data_reg  <= IHCT_RESET_BYTE;
            cop_a_wr_reg  <= 1'b0;
            cop_b_wr_reg  <= 1'b0;
            cop_a_rd_reg  <= 1'b0;
            cop_b_rd_reg  <= 1'b0;
            ext_wdata_reg <= IHCT_RESET_BYTE;
            ext_wr_reg    <= 1'b0;
            ext_rd_reg    <= 1'b0;
        end else begin
            rvalid_reg   <= data_rd;
            if (data_rd) begin
                rdata_reg <= rd_word;
            end
            cop_a_wr_reg <= byte_wr && sel_sra;
            cop_b_wr_reg <= byte_wr && sel_srb;
            cop_a_rd_reg <= data_rd && sel_sra;
            cop_b_rd_reg <= data_rd && sel_srb;
            ext_wr_reg   <= byte_wr && sel_ext;
            ext_rd_reg   <= data_rd && sel_ext;
            if (byte_wr) begin
                cop_data_reg  <= wr_byte;
                ext_wdata_reg <= wr_byte;
            end
        end
    end

    assign io_rdata        = DATA_W'(rdata_reg);
    assign io_rvalid       = rvalid_reg;
    assign cop_sr_data     = cop_data_reg;
    assign cop_sr_a_wr     = cop_a_wr_reg;
    assign cop_sr_b_wr     = cop_b_wr_reg;
    assign cop_sr_a_rd     = cop_a_rd_reg;
    assign cop_sr_b_rd     = cop_b_rd_reg;
    assign ext_index       = index_reg;
    assign ext_wdata       = ext_wdata_reg;
    assign ext_wr          = ext_wr_reg;
    assign ext_rd          = ext_rd_reg;
    assign ext_sprite_sel  = (index_reg >= IHCT_IDX_SPR_LO) &&
                             (index_reg <= IHCT_IDX_SPR_HI);
    assign ext_palette_sel = (index_reg >= IHCT_IDX_PAL_LO) &&
                             (index_reg <= IHCT_IDX_PAL_HI);

    // Timing takes effect only in extended graphics mode
    assign ext_mode = (mode_reg == IHCT_MODE_EXT);

    // Only the low byte of each pair is used; high bytes are stored for
    // readback, software keeps them zero
    ihct_htiming_t timing;
    assign timing.total       = htot_lo_reg;
    assign timing.disp_end    = hde_lo_reg;
    assign timing.blank_start = hbs_lo_reg;

    ihct_hcount u_hcount (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .enable     (ext_mode),
        .timing     (timing),
        .unit_pos   (h_unit_pos),
        .line_start (h_line_start),
        .h_active   (h_active),
        .h_blank    (h_blank)
    );
endmodule
`default_nettype wire

// file: ihct_regs_sva.sv
// Assertion checker for the indexed register port
`default_nettype none
module ihct_regs_sva
    import ihct_pkg::*;
#(
    parameter int DATA_W = 32
) (
    input wire logic              ref_clk,
    input wire logic              rst_n,
    input wire ihct_io_req_t      io_req,
    input wire logic [DATA_W-1:0] io_rdata,
    input wire logic              io_rvalid,
    input wire logic [7:0]        ext_index,
    input wire logic              ext_wr,
    input wire logic              cop_sr_a_wr,
    input wire logic              cop_sr_b_wr,
    input wire logic              ext_sprite_sel,
    input wire logic              ext_palette_sel
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic data_port = io_req.addr >= IHCT_PORT_DATA0;
    wire logic idx_wr    = io_req.wr && io_req.addr == IHCT_PORT_INDEX;
    wire logic spr_hit   = ext_index inside {[IHCT_IDX_SPR_LO:IHCT_IDX_SPR_HI]};
    wire logic pal_hit   = ext_index inside {[IHCT_IDX_PAL_LO:IHCT_IDX_PAL_HI]};
    wire logic ext_hit   = spr_hit || pal_hit ||
                           ext_index inside {[8'h16:8'h1C], IHCT_IDX_HSP_B};
    sequence s_data_rd;
        io_req.rd && data_port;
    endsequence
    sequence s_data_wr;
        io_req.wr && data_port;
    endsequence
    a_read_answer: assert property (s_data_rd |=> io_rvalid)
        else $error("data port read got no answer");
    a_stray_valid: assert property (!(io_req.rd && data_port) |=> !io_rvalid)
        else $error("answer without a data port read");
    a_index_load: assert property (idx_wr |=> ext_index == $past(io_req.wdata[7:0]))
        else $error("index not loaded from low byte");
    a_index_hold: assert property (!idx_wr |=> $stable(ext_index))
        else $error("index changed without index write");
    a_ext_decode: assert property (ext_wr |-> ext_hit)
        else $error("outer strobe for an unmapped index");
    a_cop_write: assert property (s_data_wr ##0 ext_index == IHCT_IDX_SRA |-> ##[1:2] cop_sr_a_wr)
        else $error("coprocessor image write missing");
    a_one_target: assert property (cop_sr_a_wr |-> !cop_sr_b_wr)
        else $error("two registers written by one access");
    a_sprite_sel: assert property (ext_sprite_sel == spr_hit)
        else $error("sprite select decode wrong");
    a_palette_sel: assert property (ext_palette_sel == pal_hit)
        else $error("palette select decode wrong");
endmodule
bind ihct_regs ihct_regs_sva #(.DATA_W(DATA_W)) u_sva (.ref_clk(ref_clk),
    .rst_n(rst_n), .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .ext_index(ext_index), .ext_wr(ext_wr), .cop_sr_a_wr(cop_sr_a_wr),
    .cop_sr_b_wr(cop_sr_b_wr), .ext_sprite_sel(ext_sprite_sel),
    .ext_palette_sel(ext_palette_sel));
`default_nettype wire

// file: indexed_horizontal_crt_timing_test.sv
// Self-checking bench for the indexed horizontal timing block
`default_nettype none
module indexed_horizontal_crt_timing_test import ihct_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic         ref_clk, rst_n, bus_width_flag, io_rvalid, cop_sr_a_wr;
    logic         ext_wr, h_active, h_blank, h_line_start;
    ihct_io_req_t io_req;
    logic [31:0]  io_rdata, d;
    logic [7:0]   cop_sr_data, ext_wdata, ext_index, cop_seen, ext_seen;
    logic         ok;
    int           fails, samples_checked;

    ihct_host u_host (.ref_clk(ref_clk), .io_rvalid(io_rvalid),
                      .io_rdata(io_rdata), .io_req(io_req));
    ihct_regs #(.DATA_W(32)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .bus_width_flag(bus_width_flag), .cop_sr_a_in(8'h3C),
        .cop_sr_b_in(8'h96), .cop_sr_data(cop_sr_data),
        .cop_sr_a_wr(cop_sr_a_wr), .cop_sr_b_wr(), .cop_sr_a_rd(),
        .cop_sr_b_rd(), .ext_index(ext_index), .ext_wdata(ext_wdata),
        .ext_wr(ext_wr), .ext_rd(), .ext_rdata(8'hC3), .ext_sprite_sel(),
        .ext_palette_sel(), .h_unit_pos(), .h_line_start(h_line_start),
        .h_active(h_active), .h_blank(h_blank), .ext_mode());

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // Strobes are one cycle wide, so their payload is latched here
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            cop_seen <= 8'h00;
            ext_seen <= 8'h00;
        end else begin
            if (cop_sr_a_wr === 1'b1) cop_seen <= cop_sr_data;
            if (ext_wr === 1'b1) ext_seen <= ext_wdata;
        end
    end

    task automatic stop_test();
        $display("Checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_idx(input logic [7:0] idx, input logic [7:0] v);
        u_host.io_write(IHCT_PORT_INDEX, IHCT_SZ_WORD, {16'h0, v, idx});
    endtask
    task automatic rd_chk(input logic [7:0] idx, input ihct_size_t s,
                          input logic [3:0] p, input logic [31:0] exp);
        u_host.io_write(IHCT_PORT_INDEX, IHCT_SZ_BYTE, {24'h0, idx});
        u_host.io_read(p, s, d, ok);
        chk({31'h0, ok}, 32'h1);
        chk(d, exp);
    endtask

    task automatic t_timing_rw();
        for (int i = 0; i < 6; i++) rd_chk(8'h10 + i, IHCT_SZ_BYTE, IHCT_PORT_DATA0, 0);
        for (int i = 0; i < 6; i++) wr_idx(8'h10 + i, 8'h40 + i);
        for (int i = 0; i < 6; i++) rd_chk(8'h10 + i, IHCT_SZ_BYTE, i[0] ? IHCT_PORT_DATAL : IHCT_PORT_DATA0, 32'h40 + i);
    endtask
    task automatic t_wide();
        u_host.io_write(IHCT_PORT_INDEX, IHCT_SZ_BYTE, 32'h12);
        u_host.io_write(IHCT_PORT_DATA1, IHCT_SZ_WORD, 32'h1234);
        rd_chk(8'h12, IHCT_SZ_WORD, IHCT_PORT_DATA1, 32'h1212);
        u_host.io_write(IHCT_PORT_DATA1, IHCT_SZ_DWORD, 32'hAABBCCDD);
        rd_chk(8'h12, IHCT_SZ_DWORD, IHCT_PORT_DATA1, 32'hAAAAAAAA);
        rd_chk(8'h13, IHCT_SZ_BYTE, IHCT_PORT_DATA0, 32'h43);
    endtask
    task automatic t_autocfg();
        for (int f = 1; f >= 0; f--) begin
            @(posedge ref_clk);
            #1;
            bus_width_flag = f[0];
            repeat (4) @(posedge ref_clk);
            wr_idx(IHCT_IDX_AUTOCFG, {7'h0, ~f[0]});
            u_host.io_read(IHCT_PORT_DATA0, IHCT_SZ_BYTE, d, ok);
            chk({31'h0, d[IHCT_BUS_WIDTH_BIT]}, f);
        end
    endtask
    task automatic t_outer();
        wr_idx(IHCT_IDX_SRA, 8'h5A);
        repeat (2) @(posedge ref_clk);
        chk({24'h0, cop_seen}, 32'h5A);
        u_host.io_write(IHCT_PORT_DATA0, IHCT_SZ_BYTE, 32'h77);
        repeat (2) @(posedge ref_clk);
        chk({24'h0, cop_seen}, 32'h77);
        rd_chk(IHCT_IDX_SRB, IHCT_SZ_BYTE, IHCT_PORT_DATA0, 32'h96);
        wr_idx(8'h33, 8'hA5);
        repeat (2) @(posedge ref_clk);
        chk({24'h0, ext_seen}, 32'hA5);
        rd_chk(8'h55, IHCT_SZ_BYTE, IHCT_PORT_DATA0, 32'hC3);
    endtask
    task automatic t_line();
        int lines, act, blk;
        lines = 0;
        act = 0;
        blk = 0;
        wr_idx(8'h10, 8'h09);
        wr_idx(8'h11, 8'h00);
        wr_idx(8'h12, 8'h03);
        wr_idx(8'h13, 8'h00);
        wr_idx(8'h14, 8'h06);
        wr_idx(8'h15, 8'h00);
        repeat (30) @(posedge ref_clk) lines += (h_line_start === 1'b1);
        chk(lines, 0);
        u_host.io_write(IHCT_PORT_MODE, IHCT_SZ_BYTE, {29'h0, IHCT_MODE_EXT});
        repeat (12) @(posedge ref_clk);
        repeat (20) begin
            @(posedge ref_clk);
            #1;
            lines += (h_line_start === 1'b1);
            act += (h_active === 1'b1);
            blk += (h_blank === 1'b1);
        end
        chk(lines, 2);
        chk(act, 8);
        chk(blk, 6);
    endtask

    initial begin
        #500000;
        fails++;
        $display("[ERR] %0t run did not finish", $time);
        stop_test();
    end
    initial begin
        rst_n = 1'b0;
        bus_width_flag = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_timing_rw();
        t_wide();
        t_autocfg();
        t_outer();
        t_line();
        stop_test();
    end
endmodule
`default_nettype wire
